//--- hw/tcv_pkg.sv
// constants and decode helper for the timer-three compare value block
package tcv_pkg;
  localparam int TCV_NCH = 3;
  localparam int TCV_AW = 10;
  localparam int TCV_DW = 32;
  localparam logic [7:0] TCV_IDX_A_LO = 8'h98;
  localparam logic [7:0] TCV_IDX_A_HI = 8'h99;
  localparam logic [7:0] TCV_IDX_B_LO = 8'h9a;
  localparam logic [7:0] TCV_IDX_B_HI = 8'h9b;
  localparam logic [7:0] TCV_IDX_C_LO = 8'h9e;
  localparam logic [7:0] TCV_IDX_C_HI = 8'h9f;
  localparam logic [7:0] TCV_IDX_STATUS = 8'ha0;
  localparam logic [7:0] TCV_IDX_MASK = 8'ha1;
  localparam logic [7:0] TCV_BYTE_RESET = 8'h00;
  localparam logic [15:0] TCV_VAL_RESET = 16'h0000;
  localparam logic [2:0] TCV_FLAG_RESET = 3'h0;
  localparam logic [23:0] TCV_RD_PAD = 24'h000000;

  // returns {hit, high_byte, channel[1:0]}
  function automatic logic [3:0] tcv_decode(input logic [7:0] idx);
    logic [3:0] r;
    r = 4'h0;
    case (idx)
      TCV_IDX_A_LO: r = 4'h8;
      TCV_IDX_A_HI: r = 4'hc;
      TCV_IDX_B_LO: r = 4'h9;
      TCV_IDX_B_HI: r = 4'hd;
      TCV_IDX_C_LO: r = 4'ha;
      TCV_IDX_C_HI: r = 4'he;
      default: r = 4'h0;
    endcase
    return r;
  endfunction
endpackage

//--- hw/tcv_chan_if.sv
// signals between the register logic and one compare channel
`timescale 1ns/1ns
interface tcv_chan_if;
  logic wr_commit;
  logic [15:0] wr_value;
  logic [15:0] active;
  logic [15:0] buffer;
  logic match;
  modport ctrl(output wr_commit, output wr_value, input active, input buffer, input match);
  modport chan(input wr_commit, input wr_value, output active, output buffer, output match);
endinterface

//--- hw/tcv_avs_slave.sv
// avalon-mm handshake: one wait state per access while clock enable stays high
`timescale 1ns/1ns
module tcv_avs_slave
  import tcv_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [TCV_AW-1:0] address_in,
  output logic waitrequest_out,
  output logic sample_out,
  output logic rd_accept_out,
  output logic wr_accept_out,
  output logic [7:0] index_out
);
  logic ack;
  logic next_ack;
  logic req;

  assign req = read_in | write_in;
  assign index_out = address_in[9:2];
  // a frozen cycle cannot accept, so the request keeps waiting
  assign waitrequest_out = req & ~(ack & clk_en_in);
  // first cycle of a read snapshots the data
  assign sample_out = read_in & ~ack & clk_en_in;
  assign rd_accept_out = read_in & ack & clk_en_in;
  assign wr_accept_out = write_in & ack & clk_en_in;

  always_comb begin
    next_ack = ack;
    if (clk_en_in) begin
      next_ack = req & ~ack;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end
endmodule

//--- hw/tcv_cmp_chan.sv
// one compare channel: active value, buffer and equality match
`timescale 1ns/1ns
module tcv_cmp_chan
  import tcv_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  input wire logic dbuf_in,
  input wire logic update_in,
  input wire logic tick_in,
  input wire logic [15:0] counter_in,
  tcv_chan_if.chan cif
);
  logic [15:0] next_active;
  logic [15:0] next_buffer;
  logic next_match;

  always_comb begin
    next_active = cif.active;
    next_buffer = cif.buffer;
    next_match = cif.match;
    if (clk_en_in) begin
      next_match = tick_in && (counter_in == cif.active);
      if (dbuf_in && update_in) begin
        next_active = cif.buffer;
      end
      if (cif.wr_commit) begin
        next_buffer = cif.wr_value;
        if (!dbuf_in) begin
          next_active = cif.wr_value;
        end
      end else if (!dbuf_in) begin
        next_buffer = cif.active;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cif.active <= TCV_VAL_RESET;
      cif.buffer <= TCV_VAL_RESET;
      cif.match <= 1'b0;
    end else begin
      cif.active <= next_active;
      cif.buffer <= next_buffer;
      cif.match <= next_match;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  match_equal_a: assert property (
    clk_en_in && tick_in && counter_in == cif.active |=> cif.match)
    else $error("match missing on equal count");
  match_idle_a: assert property (
    clk_en_in && !(tick_in && counter_in == cif.active) |=> !cif.match)
    else $error("match without equal count");
  dbuf_copy_a: assert property (
    clk_en_in && dbuf_in && update_in |=> cif.active == $past(cif.buffer))
    else $error("buffer not loaded at limit");
  dbuf_hold_a: assert property (
    clk_en_in && dbuf_in && !update_in |=> $stable(cif.active))
    else $error("active value changed between limits");
  buf_write_a: assert property (
    clk_en_in && dbuf_in && cif.wr_commit |=> cif.buffer == $past(cif.wr_value))
    else $error("buffered write lost");
  direct_write_a: assert property (
    clk_en_in && !dbuf_in && cif.wr_commit |=> cif.active == $past(cif.wr_value))
    else $error("direct write not immediate");
  limit_copy_c: cover property (
    clk_en_in && dbuf_in && cif.wr_commit ##[1:50] clk_en_in && update_in);
endmodule

//--- hw/tcv_top.sv
// compare value registers of the sixteen-bit timer three
`timescale 1ns/1ns
module tcv_top
  import tcv_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  input wire logic [TCV_AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [TCV_DW-1:0] avs_writedata_in,
  output logic [TCV_DW-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [15:0] counter_value_in,
  input wire logic count_tick_in,
  input wire logic pwm_mode_in,
  input wire logic count_limit_in,
  output logic [TCV_NCH-1:0] compare_match_out,
  output logic irq_out
);
  logic sample;
  logic rd_acc;
  logic wr_acc;
  logic [7:0] idx;
  logic [3:0] dec;
  logic hit;
  logic hi;
  logic [1:0] ch;
  logic be0;
  logic [7:0] wbyte;
  logic dbuf;

  logic [7:0] temp_byte;
  logic [7:0] next_temp_byte;
  logic [7:0] rd_byte;
  logic [7:0] next_rd_byte;
  logic [7:0] snap_hi;
  logic [7:0] next_snap_hi;
  logic [TCV_NCH-1:0] status;
  logic [TCV_NCH-1:0] next_status;
  logic [TCV_NCH-1:0] mask;
  logic [TCV_NCH-1:0] next_mask;

  logic [15:0] view [TCV_NCH];
  logic [TCV_NCH-1:0] match_vec;
  logic [15:0] sel_view;
  logic [TCV_NCH-1:0] clr_bits;

  tcv_chan_if cifs [TCV_NCH] ();

  tcv_avs_slave u_slave (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .read_in(avs_read_in),
    .write_in(avs_write_in),
    .address_in(avs_address_in),
    .waitrequest_out(avs_waitrequest_out),
    .sample_out(sample),
    .rd_accept_out(rd_acc),
    .wr_accept_out(wr_acc),
    .index_out(idx)
  );

  assign dbuf = pwm_mode_in;
  assign dec = tcv_decode(idx);
  assign hit = dec[3];
  assign hi = dec[2];
  assign ch = dec[1:0];
  assign be0 = avs_byteenable_in[0];
  assign wbyte = avs_writedata_in[7:0];

  for (genvar i = 0; i < TCV_NCH; i++) begin : g_ch
    tcv_cmp_chan u_chan (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .clk_en_in(clk_en_in),
      .dbuf_in(dbuf),
      .update_in(count_limit_in),
      .tick_in(count_tick_in),
      .counter_in(counter_value_in),
      .cif(cifs[i])
    );
    // low byte write commits latch and data
    assign cifs[i].wr_commit = wr_acc && be0 && hit && !hi && (ch == 2'(i));
    assign cifs[i].wr_value = {temp_byte, wbyte};
    // buffer is what software sees when buffering
    assign view[i] = dbuf ? cifs[i].buffer : cifs[i].active;
    assign match_vec[i] = cifs[i].match;
  end

  assign sel_view = (ch == 2'd0) ? view[0] : (ch == 2'd1) ? view[1] : view[2];

  // read byte and its partner are taken in the wait cycle
  always_comb begin
    next_rd_byte = rd_byte;
    next_snap_hi = snap_hi;
    if (sample) begin
      next_rd_byte = TCV_BYTE_RESET;
      if (hit && hi) begin
        // high byte reads return the latch
        next_rd_byte = temp_byte;
      end else if (hit) begin
        next_rd_byte = sel_view[7:0];
        next_snap_hi = sel_view[15:8];
      end else if (idx == TCV_IDX_STATUS) begin
        next_rd_byte = {5'h00, status};
      end else if (idx == TCV_IDX_MASK) begin
        next_rd_byte = {5'h00, mask};
      end
    end
  end

  always_comb begin
    next_temp_byte = temp_byte;
    // high byte write fills the latch
    if (wr_acc && be0 && hit && hi) begin
      next_temp_byte = wbyte;
    // low byte read captures high byte
    end else if (rd_acc && hit && !hi) begin
      next_temp_byte = snap_hi;
    end
  end

  always_comb begin
    next_mask = mask;
    clr_bits = TCV_FLAG_RESET;
    if (wr_acc && be0 && idx == TCV_IDX_MASK) begin
      next_mask = wbyte[2:0];
    end
    if (wr_acc && be0 && idx == TCV_IDX_STATUS) begin
      clr_bits = wbyte[2:0];
    end
    next_status = status;
    if (clk_en_in) begin
      // match sets flag, set beats clear
      next_status = (status & ~clr_bits) | match_vec;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      temp_byte <= TCV_BYTE_RESET;
      rd_byte <= TCV_BYTE_RESET;
      snap_hi <= TCV_BYTE_RESET;
      status <= TCV_FLAG_RESET;
      mask <= TCV_FLAG_RESET;
    end else begin
      temp_byte <= next_temp_byte;
      rd_byte <= next_rd_byte;
      snap_hi <= next_snap_hi;
      status <= next_status;
      mask <= next_mask;
    end
  end

  assign avs_readdata_out = {TCV_RD_PAD, rd_byte};
  assign compare_match_out = match_vec;
  assign irq_out = |(status & mask);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  latch_load_a: assert property (
    wr_acc && be0 && hit && hi |=> temp_byte == $past(wbyte))
    else $error("high byte not latched");
  latch_capture_a: assert property (
    sample && hit && !hi ##1 rd_acc |=> temp_byte == $past(snap_hi))
    else $error("low byte read did not capture high byte");
  a_commit_a: assert property (
    wr_acc && be0 && idx == TCV_IDX_A_LO && !dbuf
    |=> cifs[0].active == {$past(temp_byte), $past(wbyte)})
    else $error("channel a value not joined from bytes");
  a_read_low_a: assert property (
    sample && idx == TCV_IDX_A_LO |=> rd_byte == $past(view[0][7:0]))
    else $error("low byte read wrong source");
  flag_set_a: assert property (
    clk_en_in && match_vec[0]
    |=> status[0] && (irq_out == (mask[0] | (|(status[2:1] & mask[2:1])))))
    else $error("match flag not set");
  flag_clear_a: assert property (
    wr_acc && be0 && idx == TCV_IDX_STATUS && wbyte[1] && !match_vec[1] |=> !status[1])
    else $error("flag not cleared by one");

  full_write_c: cover property (
    wr_acc && hit && hi ##[1:20] wr_acc && hit && !hi);
  full_read_c: cover property (
    rd_acc && hit && !hi ##[1:20] rd_acc && hit && hi);
  irq_rise_c: cover property (!irq_out ##1 irq_out);
  bus_freeze_c: cover property (!clk_en_in && avs_read_in ##1 clk_en_in && avs_read_in);

  // bus handshake
  wait_first_a: assert property (
    (avs_read_in || avs_write_in) && !$past(avs_read_in || avs_write_in)
    |-> avs_waitrequest_out)
    else $error("new request without wait state");

  wait_once_a: assert property (
    sample ##1 clk_en_in |-> !avs_waitrequest_out)
    else $error("second cycle still waiting");

  freeze_wait_a: assert property (
    !clk_en_in && (avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("request released while frozen");

  wait_after_a: assert property (
    rd_acc || wr_acc |=> avs_waitrequest_out == (avs_read_in || avs_write_in))
    else $error("back to back request skipped wait state");

  // read path
  hi_read_a: assert property (
    sample && hit && hi |=> rd_byte == $past(temp_byte))
    else $error("high byte read not from latch");

  snap_take_a: assert property (
    sample && hit && !hi |=> snap_hi == $past(sel_view[15:8]))
    else $error("high byte not snapshotted");

  status_read_a: assert property (
    sample && idx == TCV_IDX_STATUS |=> rd_byte == {5'h00, $past(status)})
    else $error("status read wrong");

  mask_read_a: assert property (
    sample && idx == TCV_IDX_MASK |=> rd_byte == {5'h00, $past(mask)})
    else $error("mask read wrong");

  miss_read_a: assert property (
    sample && !hit && idx != TCV_IDX_STATUS && idx != TCV_IDX_MASK
    |=> rd_byte == TCV_BYTE_RESET)
    else $error("unmapped read not zero");

  c_read_buf_a: assert property (
    sample && idx == TCV_IDX_C_LO && dbuf |=> rd_byte == $past(cifs[2].buffer[7:0]))
    else $error("buffered read not from buffer");

  c_read_act_a: assert property (
    sample && idx == TCV_IDX_C_LO && !dbuf |=> rd_byte == $past(cifs[2].active[7:0]))
    else $error("direct read not from active value");

  rd_hold_a: assert property (
    !sample |=> $stable(rd_byte))
    else $error("read data changed without a read");

  // write path
  b_commit_a: assert property (
    wr_acc && be0 && idx == TCV_IDX_B_LO && !dbuf
    |=> cifs[1].active == {$past(temp_byte), $past(wbyte)})
    else $error("channel b value not joined from bytes");

  c_commit_a: assert property (
    wr_acc && be0 && idx == TCV_IDX_C_LO && !dbuf
    |=> cifs[2].active == {$past(temp_byte), $past(wbyte)})
    else $error("channel c value not joined from bytes");

  buf_commit_a: assert property (
    wr_acc && be0 && idx == TCV_IDX_A_LO && dbuf
    |=> cifs[0].buffer == {$past(temp_byte), $past(wbyte)})
    else $error("channel a buffer not written");

  b_buf_commit_a: assert property (
    wr_acc && be0 && idx == TCV_IDX_B_LO && dbuf
    |=> cifs[1].buffer == {$past(temp_byte), $past(wbyte)})
    else $error("channel b buffer not written");

  masked_write_a: assert property (
    wr_acc && !be0 |=> $stable(temp_byte) && $stable(mask))
    else $error("write without byte enable took effect");

  miss_write_a: assert property (
    wr_acc && !hit && idx != TCV_IDX_STATUS && idx != TCV_IDX_MASK
    |=> $stable(temp_byte) && $stable(mask))
    else $error("unmapped write took effect");

  mask_write_a: assert property (
    wr_acc && be0 && idx == TCV_IDX_MASK |=> mask == $past(wbyte[2:0]))
    else $error("mask write lost");

  latch_keep_a: assert property (
    !wr_acc && !rd_acc |=> $stable(temp_byte))
    else $error("latch changed without access");

  wr_hold_a: assert property (
    wr_acc && be0 && hit && !hi |=> temp_byte == $past(temp_byte))
    else $error("low byte write disturbed latch");

  // flags and interrupt
  flags_set_a: assert property (
    clk_en_in && match_vec != TCV_FLAG_RESET
    |=> (status & $past(match_vec)) == $past(match_vec))
    else $error("match did not set its flag");

  freeze_hold_a: assert property (
    !clk_en_in |=> $stable(status) && $stable(mask) && $stable(temp_byte) && $stable(rd_byte))
    else $error("state moved while frozen");

  irq_on_a: assert property (
    (status & mask) != TCV_FLAG_RESET |-> irq_out)
    else $error("interrupt missing for unmasked flag");

  irq_off_a: assert property (
    (status & mask) == TCV_FLAG_RESET |-> !irq_out)
    else $error("interrupt without unmasked flag");
endmodule

//--- verification/tcv_top_test.sv
// self-checking bench for the timer-three compare value block
`timescale 1ns/1ns
module tcv_top_test;
  import tcv_pkg::*;
  logic clk_in;
  logic srst_in;
  logic clk_en_in;
  logic [TCV_AW-1:0] avs_address_in;
  logic avs_read_in;
  logic avs_write_in;
  logic [3:0] avs_byteenable_in;
  logic [TCV_DW-1:0] avs_writedata_in;
  logic [TCV_DW-1:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [15:0] counter_value_in;
  logic count_tick_in;
  logic pwm_mode_in;
  logic count_limit_in;
  logic [TCV_NCH-1:0] compare_match_out;
  logic irq_out;
  logic [31:0] q;
  int miscompares;
  int tests_run;

  tcv_top DUT (.clk_in(clk_in), .srst_in(srst_in), .clk_en_in(clk_en_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .counter_value_in(counter_value_in),
    .count_tick_in(count_tick_in), .pwm_mode_in(pwm_mode_in),
    .count_limit_in(count_limit_in), .compare_match_out(compare_match_out),
    .irq_out(irq_out));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one avalon access, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic rd, input logic [7:0] idx, input logic [7:0] d,
      input logic [3:0] be, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= {idx, 2'b00};
    avs_writedata_in <= {24'h000000, d};
    avs_byteenable_in <= be;
    avs_read_in <= rd;
    avs_write_in <= ~rd;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) chk("bus wait", 32'h1, 32'h0);
    r = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b0, idx, d, 4'h1, q);
  endtask

  task automatic rchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b1, idx, 8'h00, 4'h0, q);
    chk(name, q, {24'h000000, exp});
  endtask

  // present a count for one cycle and look at the match one cycle later
  task automatic tick_at(input logic [15:0] cnt, input logic tk, input logic [2:0] exp);
    @(posedge clk_in);
    counter_value_in <= cnt;
    count_tick_in <= tk;
    @(posedge clk_in);
    count_tick_in <= 1'b0;
    @(negedge clk_in);
    chk("match", {29'h0, compare_match_out}, {29'h0, exp});
    @(negedge clk_in);
    chk("match end", {29'h0, compare_match_out}, 32'h0);
  endtask

  task automatic t_reset();
    logic [7:0] idx [6];
    idx = '{TCV_IDX_A_LO, TCV_IDX_A_HI, TCV_IDX_B_LO, TCV_IDX_B_HI, TCV_IDX_C_LO,
      TCV_IDX_C_HI};
    foreach (idx[i]) rchk("reset value", idx[i], 8'h00);
    rchk("unmapped", 8'h10, 8'h00);
    @(negedge clk_in);
    chk("irq reset", {31'h0, irq_out}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_direct();
    wr(TCV_IDX_A_HI, 8'h12);
    wr(TCV_IDX_A_LO, 8'h34);
    wr(TCV_IDX_B_HI, 8'h12);
    wr(TCV_IDX_B_LO, 8'h34);
    wr(TCV_IDX_C_HI, 8'h55);
    bus(1'b0, TCV_IDX_C_LO, 8'h66, 4'he, q);
    rchk("c low masked", TCV_IDX_C_LO, 8'h00);
    // the read above refilled the latch, so the high byte goes first again
    wr(TCV_IDX_C_HI, 8'h55);
    wr(TCV_IDX_C_LO, 8'h66);
    rchk("a low", TCV_IDX_A_LO, 8'h34);
    rchk("a high", TCV_IDX_A_HI, 8'h12);
    rchk("c low", TCV_IDX_C_LO, 8'h66);
    rchk("c high", TCV_IDX_C_HI, 8'h55);
    tick_at(16'h1234, 1'b0, 3'b000);
    tick_at(16'h1234, 1'b1, 3'b011);
    tick_at(16'h5566, 1'b1, 3'b100);
    tick_at(16'h1235, 1'b1, 3'b000);
    $display("test direct done");
  endtask

  task automatic t_irq();
    rchk("status", TCV_IDX_STATUS, 8'h07);
    @(negedge clk_in);
    chk("irq masked", {31'h0, irq_out}, 32'h0);
    wr(TCV_IDX_MASK, 8'h02);
    rchk("mask", TCV_IDX_MASK, 8'h02);
    @(negedge clk_in);
    chk("irq on", {31'h0, irq_out}, 32'h1);
    wr(TCV_IDX_STATUS, 8'h02);
    @(negedge clk_in);
    chk("irq cleared", {31'h0, irq_out}, 32'h0);
    rchk("status left", TCV_IDX_STATUS, 8'h05);
    wr(TCV_IDX_STATUS, 8'h05);
    rchk("status clear", TCV_IDX_STATUS, 8'h00);
    $display("test irq done");
  endtask

  task automatic t_pwm();
    @(posedge clk_in);
    pwm_mode_in <= 1'b1;
    wr(TCV_IDX_A_HI, 8'h00);
    wr(TCV_IDX_A_LO, 8'h10);
    rchk("buffer low", TCV_IDX_A_LO, 8'h10);
    rchk("buffer high", TCV_IDX_A_HI, 8'h00);
    tick_at(16'h0010, 1'b1, 3'b000);
    tick_at(16'h1234, 1'b1, 3'b011);
    @(posedge clk_in);
    count_limit_in <= 1'b1;
    @(posedge clk_in);
    count_limit_in <= 1'b0;
    tick_at(16'h0010, 1'b1, 3'b001);
    tick_at(16'h1234, 1'b1, 3'b010);
    $display("test pwm done");
  endtask

  // clock enable low: no compare, no flag, the pending read keeps waiting
  task automatic t_freeze();
    int n;
    n = 0;
    wr(TCV_IDX_STATUS, 8'h07);
    @(posedge clk_in);
    clk_en_in <= 1'b0;
    counter_value_in <= 16'h1234;
    count_tick_in <= 1'b1;
    avs_address_in <= {TCV_IDX_STATUS, 2'b00};
    avs_read_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk("frozen match", {29'h0, compare_match_out}, 32'h0);
    chk("frozen irq", {31'h0, irq_out}, 32'h0);
    chk("frozen wait", {31'h0, avs_waitrequest_out}, 32'h1);
    @(posedge clk_in);
    count_tick_in <= 1'b0;
    clk_en_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    chk("frozen status", avs_readdata_out, 32'h0);
    avs_read_in <= 1'b0;
    $display("test freeze done");
  endtask

  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end

  initial begin
    miscompares = 0;
    tests_run = 0;
    srst_in = 1'b1;
    clk_en_in = 1'b1;
    avs_address_in = '0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_byteenable_in = 4'h0;
    avs_writedata_in = '0;
    counter_value_in = 16'h0000;
    count_tick_in = 1'b0;
    pwm_mode_in = 1'b0;
    count_limit_in = 1'b0;
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset();
    t_direct();
    t_irq();
    t_pwm();
    t_freeze();
    give_verdict();
  end
endmodule
